/* File: rtl/tx_framer_pkg.sv */
/*
   Constants, types and carriers for the per-link SONET transmit frame formatter.
   Assumes a single synchronous clock domain and one link per instance.
*/
// Operation
// - Each link instance carries one STS-48 rate stream on its own.
// - Formatter accepts one 32-bit word per transmit system clock.
// - Frame-start pulse marks first word; position counters realign to it.
// - Frame has 9 rows, each with 144 overhead bytes then payload.
// - Each row is 36 overhead word cycles then 1044 payload cycles.
// - One 125 us frame spans 9 rows of 1080 word cycles.
// - Transparent mode forwards all overhead untouched; only scrambles and serializes.
// - Automatic modes overwrite selected overhead bytes before scrambling.
// - Framing insertion places F6 and 28 in every STS-1 framing slot.
// - Section mode: computed B1 in first STS-1, 00 in others.
// - Framing insertion and B1 insertion have separate enables.
// - Section mode overwrites K2 only while remote defect inject is set.
// - Full mode: pointer bytes 62/0A first, 93/FF others; listed bytes 00.
// - Full mode: J0 ID every fourth STS-1, F1 link number, K2 RDI.
// - Framing corruption sends inverted A1 and A2 values.
// - Parity error forcing sends the inverted computed B1.
// - Remote defect injection forces first STS-1 K2 to 00000110.
// - Words are scrambled in parallel with 1 + x^6 + x^7.
// - A disable bit makes words leave the scrambler unchanged.
// - Words are serialized to bytes through a small elastic store.
// - A divide-by-4 word clock is derived from the byte rate.
// - B1 computed over one frame is sent in the next frame.
// - A1, A2 and J0 stay unscrambled; all other bytes are scrambled.
package tx_framer_pkg;

   // Frame geometry.
   localparam int ROWS = 9;
   localparam int STS_COUNT = 48;
   localparam int TOH_COLS = 3;
   localparam int TOH_WORDS = 36;
   localparam int PAYLOAD_WORDS = 1044;
   localparam int ROW_WORDS = TOH_WORDS + PAYLOAD_WORDS;
   localparam int BYTES_PER_WORD = 4;
   localparam logic [3:0] LAST_ROW = 4'h8;
   localparam logic [10:0] LAST_WORD = 11'(ROW_WORDS - 1);
   localparam logic [10:0] TOH_LIMIT = 11'(TOH_WORDS);

   // Frame period check: 125 us of 77.76 MHz word cycles.
   localparam int FRAME_TIME_NS = 125000;
   localparam int WORD_CLOCK_KHZ = 77760;
   localparam int FRAME_WORDS = (FRAME_TIME_NS / 1000) * WORD_CLOCK_KHZ / 1000;

   // Overhead rows and columns.
   localparam logic [3:0] ROW_FRAMING = 4'h0;
   localparam logic [3:0] ROW_PARITY = 4'h1;
   localparam logic [3:0] ROW_POINTER = 4'h3;
   localparam logic [3:0] ROW_APS = 4'h4;
   localparam logic [1:0] COL_FIRST = 2'h0;
   localparam logic [1:0] COL_SECOND = 2'h1;
   localparam logic [1:0] COL_THIRD = 2'h2;
   localparam logic [1:0] TRACE_SPACING_MASK = 2'h3;

   // Inserted byte values.
   localparam logic [7:0] A1_VALUE = 8'hf6;
   localparam logic [7:0] A2_VALUE = 8'h28;
   localparam logic [7:0] H1_FIRST = 8'h62;
   localparam logic [7:0] H2_FIRST = 8'h0a;
   localparam logic [7:0] H1_OTHER = 8'h93;
   localparam logic [7:0] H2_OTHER = 8'hff;
   localparam logic [7:0] K2_RDI = 8'h06;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // Scrambler seed and elastic store.
   localparam logic [6:0] SCRAMBLE_SEED = 7'h7f;
   localparam int FIFO_DEPTH = 16;
   localparam int WORD_WIDTH = 32;
   localparam logic [1:0] LAST_LANE = 2'h3;

   typedef enum logic [1:0] {
      transparent_mode = 2'h0,
      section_overhead_auto_mode = 2'h1,
      full_overhead_auto_mode = 2'h2
   } overhead_mode_t;

   typedef enum logic [1:0] {
      ser_idle = 2'h1,
      ser_shift = 2'h2
   } ser_state_t;

   // Static per-link controls.
   typedef struct packed {
      overhead_mode_t mode;
      logic framing_insert;
      logic parity_insert;
      logic framing_corrupt;
      logic parity_corrupt;
      logic remote_defect_inject_bit;
      logic scramble_disable;
      logic [7:0] link_number;
   } cfg_t;

   // Serializer output group.
   typedef struct packed {
      logic [7:0] data;
      logic valid;
      logic word_clock;
   } line_out_t;

endpackage

/* File: rtl/transmit_frame_formatter.sv */
/*
   Transmit frame formatter for one SONET link: overhead insertion, parity,
   scrambling, a 16-word elastic store and a 32:8 serializer, plus the store.
   Assumes fabric words synchronous to clock and controls held static per frame.
*/
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module sync_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // Clocking.
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // Filling side.
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Draining side.
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
      logic ready;
   } fifo_state_t;

   fifo_state_t state;
   fifo_state_t next_state;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // Ready is a flop so it never forms a loop through the source.
   always_comb
   begin
      push = ce && in_valid && state.ready;
      pop = ce && out_ready && (state.count != '0);
      next_state = state;
      if (push)
      begin
         next_state.wr = state.wr + 1'b1;
      end
      if (pop)
      begin
         next_state.rd = state.rd + 1'b1;
      end
      next_state.count = state.count + (AW+1)'(push) - (AW+1)'(pop);
      next_state.ready = next_state.count < (AW+1)'(DEPTH);
   end

   // State register; frozen while the clock enable is low.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state <= '{wr: '0, rd: '0, count: '0, ready: 1'b1};
      end
      else if (ce)
      begin
         state <= next_state;
      end
   end

   // Storage array, written only on an accepted word.
   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem[state.wr] <= in_data;
      end
   end

   assign in_ready = state.ready;
   assign out_valid = state.count != '0;
   assign out_data = mem[state.rd];
endmodule

////////////////////////////////////////////////////////////////////////////////

module transmit_frame_formatter (
   // Clocking.
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // Static controls.
   input wire tx_framer_pkg::cfg_t cfg,
   // Fabric word stream.
   input wire logic [31:0] tx_word,
   input wire logic tx_word_valid,
   input wire logic tx_frame_start_pulse,
   output logic tx_ready,
   // Serializer output.
   output var tx_framer_pkg::line_out_t line_out
);

   typedef struct packed {
      logic [3:0] row;
      logic [10:0] word;
      logic [6:0] scr;
      logic [7:0] parity_acc;
      logic [7:0] parity_last;
      tx_framer_pkg::ser_state_t ser;
      logic [1:0] div;
      logic [31:0] shift;
      tx_framer_pkg::line_out_t out;
   } state_t;

   state_t state;
   state_t next_state;
   logic take;
   logic [3:0] pos_row;
   logic [10:0] pos_word;
   logic in_toh;
   logic keep_clear;
   logic [31:0] formatted;
   logic [31:0] push_data;
   logic [38:0] scrambled;
   logic fifo_valid;
   logic [31:0] fifo_data;
   logic fifo_pop;

   // Overhead substitution for one byte at (row, column, STS-1 index).
   function automatic logic [7:0] overhead_byte(
      input tx_framer_pkg::cfg_t c,
      input logic [3:0] row,
      input logic [1:0] col,
      input logic [5:0] sts,
      input logic [7:0] in_byte,
      input logic [7:0] parity
   );
      logic first;
      logic full;
      logic [7:0] res;
      first = (sts == '0);
      full = (c.mode == tx_framer_pkg::full_overhead_auto_mode);
      res = in_byte;
      case (row)
         tx_framer_pkg::ROW_FRAMING:
         begin
            if (col == tx_framer_pkg::COL_FIRST && c.framing_insert)
            begin
               res = tx_framer_pkg::A1_VALUE ^ {8{c.framing_corrupt}};
            end
            else if (col == tx_framer_pkg::COL_SECOND && c.framing_insert)
            begin
               res = tx_framer_pkg::A2_VALUE ^ {8{c.framing_corrupt}};
            end
            else if (col == tx_framer_pkg::COL_THIRD && full)
            begin
               // Identity goes in every fourth STS-1, counted from one.
               res = ((sts[1:0] & tx_framer_pkg::TRACE_SPACING_MASK) == 2'h0) ?
                     {2'h0, sts + 6'h01} : tx_framer_pkg::ZERO_BYTE;
            end
         end
         tx_framer_pkg::ROW_PARITY:
         begin
            if (col == tx_framer_pkg::COL_FIRST && c.parity_insert)
            begin
               res = first ? (parity ^ {8{c.parity_corrupt}}) :
                     tx_framer_pkg::ZERO_BYTE;
            end
            else if (col == tx_framer_pkg::COL_THIRD && full)
            begin
               res = first ? c.link_number : tx_framer_pkg::ZERO_BYTE;
            end
            else if (full)
            begin
               res = tx_framer_pkg::ZERO_BYTE;
            end
         end
         tx_framer_pkg::ROW_POINTER:
         begin
            if (full)
            begin
               case (col)
                  tx_framer_pkg::COL_FIRST:
                     res = first ? tx_framer_pkg::H1_FIRST : tx_framer_pkg::H1_OTHER;
                  tx_framer_pkg::COL_SECOND:
                     res = first ? tx_framer_pkg::H2_FIRST : tx_framer_pkg::H2_OTHER;
                  default:
                     res = tx_framer_pkg::ZERO_BYTE;
               endcase
            end
         end
         tx_framer_pkg::ROW_APS:
         begin
            if (col == tx_framer_pkg::COL_THIRD && first && c.remote_defect_inject_bit)
            begin
               res = tx_framer_pkg::K2_RDI;
            end
            else if (full)
            begin
               res = tx_framer_pkg::ZERO_BYTE;
            end
         end
         default:
         begin
            if (full)
            begin
               res = tx_framer_pkg::ZERO_BYTE;
            end
         end
      endcase
      return res;
   endfunction

   // Parallel frame-synchronous scrambler; returns {word, next seed}.
   function automatic logic [38:0] scramble_word(
      input logic [6:0] seed,
      input logic [31:0] din
   );
      logic [6:0] s;
      logic [31:0] d;
      s = seed;
      d = din;
      for (int i = 31; i >= 0; i--)
      begin
         d[i] = din[i] ^ s[6];
         s = {s[5:0], s[6] ^ s[5]};
      end
      return {d, s};
   endfunction

   ////////////////////////////////////////////////////////////////////////////

   // The elastic store between formatting and serialization.
   sync_fifo #(
      .WIDTH(tx_framer_pkg::WORD_WIDTH),
      .DEPTH(tx_framer_pkg::FIFO_DEPTH)
   ) elastic_store (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .in_valid(take),
      .in_data(push_data),
      .in_ready(tx_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(fifo_pop)
   );

   // A word is taken only while the store has room, so the fabric is stalled.
   assign take = ce && tx_word_valid && tx_ready;
   assign fifo_pop = (state.div == tx_framer_pkg::LAST_LANE);

   // Position of the current word; the pulse forces row 0, word 0.
   always_comb
   begin
      pos_row = tx_frame_start_pulse ? '0 : state.row;
      pos_word = tx_frame_start_pulse ? '0 : state.word;
      in_toh = pos_word < tx_framer_pkg::TOH_LIMIT;
      keep_clear = in_toh && (pos_row == tx_framer_pkg::ROW_FRAMING);
   end

   // Overhead insertion over the four byte lanes, most significant first.
   always_comb
   begin
      int b;
      b = 0;
      formatted = tx_word;
      if (in_toh && cfg.mode != tx_framer_pkg::transparent_mode)
      begin
         for (int lane = 0; lane < tx_framer_pkg::BYTES_PER_WORD; lane++)
         begin
            b = int'(pos_word) * tx_framer_pkg::BYTES_PER_WORD + lane;
            formatted[31-8*lane -: 8] = overhead_byte(cfg, pos_row,
               2'(b / tx_framer_pkg::STS_COUNT), 6'(b % tx_framer_pkg::STS_COUNT),
               tx_word[31-8*lane -: 8], state.parity_last);
         end
      end
   end

   // Scrambling: seed restarts at each frame, row 0 overhead is left clear.
   always_comb
   begin
      scrambled = scramble_word((pos_row == '0 && pos_word == '0) ?
                                tx_framer_pkg::SCRAMBLE_SEED : state.scr, formatted);
      if (keep_clear || cfg.scramble_disable)
      begin
         push_data = formatted;
      end
      else
      begin
         push_data = scrambled[38:7];
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   // Next state: frame counters, parity, serializer and word clock.
   always_comb
   begin
      next_state = state;
      if (take)
      begin
         if (pos_row == '0 && pos_word == '0)
         begin
            // Completed parity moves to the slot for the following frame.
            next_state.parity_last = state.parity_acc;
            next_state.parity_acc = '0;
            next_state.scr = tx_framer_pkg::SCRAMBLE_SEED;
         end
         if (!keep_clear)
         begin
            next_state.scr = scrambled[6:0];
            next_state.parity_acc = ((pos_row == '0 && pos_word == '0) ? 8'h00 :
               state.parity_acc) ^ push_data[31:24] ^ push_data[23:16] ^
               push_data[15:8] ^ push_data[7:0];
         end
         // One frame is nine rows of 1080 word cycles.
         if (pos_word == tx_framer_pkg::LAST_WORD)
         begin
            next_state.word = '0;
            next_state.row = (pos_row == tx_framer_pkg::LAST_ROW) ? '0 : pos_row + 4'h1;
         end
         else
         begin
            next_state.word = pos_word + 11'h001;
            next_state.row = pos_row;
         end
      end
      // Free-running divide-by-4 defines the word clock and byte lanes.
      next_state.div = state.div + 2'h1;
      next_state.out.word_clock = next_state.div[1];
      if (fifo_pop)
      begin
         if (fifo_valid)
         begin
            next_state.ser = tx_framer_pkg::ser_shift;
            next_state.shift = {fifo_data[23:0], 8'h00};
            next_state.out.data = fifo_data[31:24];
            next_state.out.valid = 1'b1;
         end
         else
         begin
            // Underrun shows as a gap of four invalid bytes.
            next_state.ser = tx_framer_pkg::ser_idle;
            next_state.out.valid = 1'b0;
         end
      end
      else
      begin
         case (state.ser)
            tx_framer_pkg::ser_shift:
            begin
               next_state.out.data = state.shift[31:24];
               next_state.shift = {state.shift[23:0], 8'h00};
               next_state.out.valid = 1'b1;
            end
            tx_framer_pkg::ser_idle:
               next_state.out.valid = 1'b0;
            default:
            begin
               next_state.ser = tx_framer_pkg::ser_idle;
               next_state.out.valid = 1'b0;
            end
         endcase
      end
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state <= '{row: '0, word: '0, scr: tx_framer_pkg::SCRAMBLE_SEED,
                    parity_acc: '0, parity_last: '0, ser: tx_framer_pkg::ser_idle,
                    div: '0, shift: '0, out: '0};
      end
      else if (ce)
      begin
         state <= next_state;
      end
   end

   assign line_out = state.out;

   ////////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   logic plain_auto;
   assign plain_auto = take && cfg.mode != tx_framer_pkg::transparent_mode &&
                       cfg.scramble_disable;

   sequence pop_word_s;
      ce && fifo_pop && fifo_valid;
   endsequence

   sequence frame_end_s;
      take && !tx_frame_start_pulse && state.row == tx_framer_pkg::LAST_ROW &&
      state.word == tx_framer_pkg::LAST_WORD;
   endsequence

   framing_value_a: assert property (plain_auto && pos_row == '0 && pos_word == '0 &&
      cfg.framing_insert && !cfg.framing_corrupt |-> push_data == {4{tx_framer_pkg::A1_VALUE}})
      else $error("framing bytes not inserted");

   framing_corrupt_a: assert property (plain_auto && pos_row == '0 &&
      pos_word == 11'h00c && cfg.framing_insert && cfg.framing_corrupt |->
      push_data == {4{~tx_framer_pkg::A2_VALUE}})
      else $error("corrupted framing bytes wrong");

   parity_slot_a: assert property (plain_auto && pos_row == tx_framer_pkg::ROW_PARITY &&
      pos_word == '0 && cfg.parity_insert |->
      push_data == {state.parity_last ^ {8{cfg.parity_corrupt}}, 24'h000000})
      else $error("parity byte slot wrong");

   transparent_pass_a: assert property (take && cfg.scramble_disable &&
      cfg.mode == tx_framer_pkg::transparent_mode |-> push_data == tx_word)
      else $error("transparent word altered");

   k2_defect_a: assert property (plain_auto && pos_row == tx_framer_pkg::ROW_APS &&
      pos_word == 11'h018 && cfg.remote_defect_inject_bit |->
      push_data[31:24] == tx_framer_pkg::K2_RDI)
      else $error("defect code missing from K2");

   pointer_bytes_a: assert property (plain_auto && pos_row == tx_framer_pkg::ROW_POINTER &&
      pos_word == '0 && cfg.mode == tx_framer_pkg::full_overhead_auto_mode |->
      push_data == {tx_framer_pkg::H1_FIRST, {3{tx_framer_pkg::H1_OTHER}}})
      else $error("pointer bytes wrong");

   clear_header_a: assert property (take && keep_clear &&
      cfg.mode == tx_framer_pkg::transparent_mode |-> push_data == tx_word)
      else $error("framing row overhead was scrambled");

   frame_wrap_a: assert property (frame_end_s |=> state.row == '0 && state.word == '0)
      else $error("frame counters did not wrap");

   frame_align_a: assert property (take && tx_frame_start_pulse |=>
      state.row == '0 && state.word == 11'h001 &&
      state.scr == tx_framer_pkg::SCRAMBLE_SEED && state.parity_acc == '0)
      else $error("counters not aligned to frame start");

   stall_source_a: assert property (!tx_ready && !(ce && fifo_pop) |=> !tx_ready)
      else $error("store left full state without a pop");

   first_byte_a: assert property (pop_word_s |=> line_out.valid &&
      line_out.data == $past(fifo_data[31:24]))
      else $error("serializer first byte wrong");

   second_byte_a: assert property (pop_word_s ##1 ce |=>
      line_out.data == $past(fifo_data[23:16], 2))
      else $error("serializer byte order wrong");

   word_clock_a: assert property (!rst && ce ##1 ce |->
      line_out.word_clock == state.div[1] && $past(state.div) + 2'h1 == state.div)
      else $error("word clock not divide by four");
endmodule

`default_nettype wire

/* File: verif/fabric_source.sv */
/*
   Fabric-side word source for the transmit frame formatter.
   Assumes it shares the formatter clock and holds each word until it is taken.
*/
`timescale 1ns/10ps
`default_nettype none

module fabric_source (
   // Clocking, same clock as the formatter.
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // Commands from the bench.
   input wire logic start,
   input wire logic [15:0] count,
   input wire logic gap,
   output logic busy,
   // Word stream.
   output logic [31:0] tx_word,
   output logic tx_word_valid,
   output logic tx_frame_start_pulse,
   input wire logic tx_ready
);
   int k;
   int left;

   function automatic logic [31:0] pat(int n);
      return 32'(n) * 32'h9e3779b1;
   endfunction

   assign busy = left != 0;

   // Sends words in frame order; an idle data bus shows inverted data, not the old word.
   always @(posedge clock)
      if (rst)
      begin
         tx_word_valid <= 1'b0;
         tx_frame_start_pulse <= 1'b0;
         tx_word <= 32'h00000000;
         left <= 0;
      end
      else if (start)
      begin
         k <= 0;
         left <= int'(count);
         tx_word_valid <= 1'b1;
         tx_frame_start_pulse <= 1'b1;
         tx_word <= pat(0);
      end
      else if (tx_word_valid && tx_ready && ce)
      begin
         tx_frame_start_pulse <= 1'b0;
         k <= k + 1;
         left <= left - 1;
         tx_word_valid <= left > 1 && !gap;
         tx_word <= (left > 1 && !gap) ? pat(k + 1) : ~pat(k);
      end
      else if (!tx_word_valid && left != 0)
      begin
         tx_word_valid <= 1'b1;
         tx_word <= pat(k);
      end
endmodule

`default_nettype wire

/* File: verif/test_transmit_frame_formatter.sv */
/*
   Self-checking bench for the transmit frame formatter.
   Assumes the fabric source model and one 40 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none

module test_transmit_frame_formatter;
   typedef struct {tx_framer_pkg::cfg_t c; logic g; logic [15:0] n;} row_t;
   logic clock;
   logic rst;
   logic ce;
   logic start;
   logic gap;
   logic busy;
   logic full_seen;
   logic [15:0] count;
   logic [31:0] tx_word;
   logic tx_word_valid;
   logic tx_frame_start_pulse;
   logic tx_ready;
   tx_framer_pkg::cfg_t cfg;
   tx_framer_pkg::line_out_t line_out;
   row_t rows[3];
   logic [63:0] q[$];
   logic [63:0] cur;
   logic [8:0] e;
   logic [7:0] par_acc;
   logic [7:0] par_last;
   int kin;
   int lane;
   int n_fail = 0;
   int checked = 0;

   transmit_frame_formatter dut (.clock(clock), .rst(rst), .ce(ce), .cfg(cfg),
      .tx_word(tx_word), .tx_word_valid(tx_word_valid),
      .tx_frame_start_pulse(tx_frame_start_pulse), .tx_ready(tx_ready), .line_out(line_out));
   fabric_source src (.clock(clock), .rst(rst), .ce(ce), .start(start), .count(count),
      .gap(gap), .busy(busy), .tx_word(tx_word), .tx_word_valid(tx_word_valid),
      .tx_frame_start_pulse(tx_frame_start_pulse), .tx_ready(tx_ready));

   task automatic check(logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Expected line byte; bit 8 says whether it can be predicted without the scrambler.
   function automatic logic [8:0] exp_byte(tx_framer_pkg::cfg_t c, int k, int ln,
      logic [7:0] d, logic [7:0] p);
      int row, w, col, sts;
      logic [7:0] x;
      row = (k / 1080) % 9;
      w = k % 1080;
      col = (w * 4 + ln) / 48;
      sts = (w * 4 + ln) % 48;
      x = d;
      if (w >= 36)
         return {c.scramble_disable, d};
      if (c.mode != tx_framer_pkg::transparent_mode)
      begin
         if (row == 0 && col < 2 && c.framing_insert)
            x = (col == 0 ? 8'hf6 : 8'h28) ^ {8{c.framing_corrupt}};
         if (c.mode == tx_framer_pkg::full_overhead_auto_mode)
         begin
            if (row == 0 && col == 2)
               x = (sts % 4 == 0) ? 8'(sts + 1) : 8'h00;
            if (row == 1)
               x = (col == 2 && sts == 0) ? c.link_number : 8'h00;
            if (row >= 2)
               x = 8'h00;
            if (row == 3 && col == 0)
               x = sts == 0 ? 8'h62 : 8'h93;
            if (row == 3 && col == 1)
               x = sts == 0 ? 8'h0a : 8'hff;
         end
         if (row == 1 && col == 0 && c.parity_insert)
         begin
            // B1 of a frame carries the parity of the frame before it.
            if (sts == 0)
               return {c.scramble_disable, p ^ {8{c.parity_corrupt}}};
            x = 8'h00;
         end
         if (row == 4 && col == 2 && sts == 0 && c.remote_defect_inject_bit)
            x = 8'h06;
      end
      return {c.scramble_disable || row == 0, x};
   endfunction

   // Reference store: words taken in, bytes compared out in the same order.
   always @(posedge clock)
      if (rst)
      begin
         q.delete();
         par_acc = 8'h00;
         par_last = 8'h00;
         lane = 0;
         kin = 0;
      end
      else
      begin
         if (!tx_ready)
            full_seen = 1'b1;
         if (ce && tx_word_valid && tx_ready)
         begin
            kin = tx_frame_start_pulse ? 0 : kin + 1;
            q.push_back({32'(kin), tx_word});
         end
         if (ce && line_out.valid)
         begin
            if (lane == 0)
            begin
               cur = q.pop_front();
               // Parity of the finished frame is latched as the next frame's first byte leaves.
               if (int'(cur[63:32]) % 9720 == 0)
               begin
                  par_last = par_acc;
                  par_acc = 8'h00;
               end
            end
            e = exp_byte(cfg, int'(cur[63:32]), lane, cur[31 - 8 * lane -: 8], par_last);
            if (e[8])
               check(32'(line_out.data), 32'(e[7:0]));
            check(32'(line_out.word_clock), 32'(lane >= 2));
            if (int'(cur[63:32]) % 9720 >= 36)
               par_acc = par_acc ^ line_out.data;
            lane = (lane + 1) % 4;
         end
      end

   task automatic run(logic [15:0] n);
      int t;
      count <= n;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      @(posedge clock);
      for (t = 0; t < 50000 && busy; t++)
         @(posedge clock);
   endtask

   task automatic reset_dut();
      rst <= 1'b1;
      repeat (8) @(posedge clock);
      #1;
      check(32'(line_out), 32'h00000000);
      check(32'(tx_ready), 32'h00000001);
      @(posedge clock);
      rst <= 1'b0;
   endtask

   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   initial
   begin
      #2400000;
      n_fail++;
      test_done();
   end

   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      start = 1'b0;
      gap = 1'b0;
      count = 16'h0000;
      full_seen = 1'b0;
      cfg = '0;
      rows[0] = '{'{tx_framer_pkg::transparent_mode, 0, 0, 0, 0, 0, 1, 8'h00}, 1'b0, 16'h111c};
      rows[1] = '{'{tx_framer_pkg::section_overhead_auto_mode, 1, 1, 0, 1, 1, 1, 8'h00},
         1'b1, 16'h111c};
      rows[2] = '{'{tx_framer_pkg::full_overhead_auto_mode, 1, 1, 1, 0, 1, 1, 8'h2a}, 1'b0,
         16'h2a34};
      // Each row runs through row 4 overhead; the last one wraps into a second frame for B1.
      foreach (rows[i])
      begin
         reset_dut();
         cfg <= rows[i].c;
         gap <= rows[i].g;
         run(rows[i].n);
         repeat (100) @(posedge clock);
         check(32'(q.size()), 32'h00000000);
      end
      // Scrambled stream restarted mid-frame, with a clock-enable freeze.
      reset_dut();
      cfg <= '{tx_framer_pkg::transparent_mode, 0, 0, 0, 0, 0, 0, 8'h00};
      gap <= 1'b0;
      run(16'h0028);
      ce <= 1'b0;
      repeat (10) @(posedge clock);
      ce <= 1'b1;
      run(16'h0024);
      repeat (200) @(posedge clock);
      check(32'(q.size()), 32'h00000000);
      check(32'(full_seen), 32'h00000001);
      test_done();
   end
endmodule

`default_nettype wire
